/* File: rtl/lcd_host_port.sv */
// LCD controller host port: strap configuration, window decode, wait-state insertion.
// Assumes the host bus is synchronous to pclk and the host holds a cycle until wait_n rises.
//
// Summary of operation
// [R01] Straps and bus status sampled at reset release
// [R02] Top strap: low little, high big endian
// [R03] Low straps choose the 16-bit protocol
// [R04] Variable wait states from sync and refresh
// [R05] Host routes wait to transfer acknowledge
// [R06] Glue inverts wait, driving only under select
// [R07] Device occupies one 128K byte window
// [R08] Registers in top 32 bytes of window
// [R09] 80K display buffer at window base
// [R10] Host select wait field set to 111b
// [R11] Host select read-only attribute cleared
// [R12] Strobe pins in other use: generic one
// [R13] Prefer 64K group, avoid boot, card selects
// [R14] Wait held low until data valid, accepted
// [R15] Generic one: enables qualify byte lanes
// [R16] Strap values held until next reset
`timescale 1ns/10ps
`include "host_port_params.svh"
module lcd_host_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration straps
  input wire logic endian_strap,
  input wire logic bus_select_strap_high,
  input wire logic bus_select_strap_mid,
  input wire logic bus_select_strap_low,
  // Host bus
  host_port_if.device bus,
  // Status
  output logic endian_big,
  output host_port_pkg::host_mode_e active_mode,
  output logic refresh_busy
);
  import host_port_pkg::*;

  function automatic logic [15:0] swap16(input logic [15:0] x);
    swap16 = {x[7:0], x[15:8]};
  endfunction

  function automatic logic [4:0] refresh_len(input logic [1:0] m);
    refresh_len = `REFRESH_ONE << m;
  endfunction

  logic captured;
  logic [15:0] mem [0:`BUF_WORDS-1];
  logic [15:0] regs [0:`REG_WORDS-1];
  dev_state_e state;
  logic [1:0] sync_count;
  logic [3:0] ref_count;
  logic [16:0] cap_addr;
  logic cap_wr;
  logic cap_lo;
  logic cap_hi;
  logic [15:0] cap_wdata;

  strap_latch straps (
    .pclk(pclk),
    .presetn(presetn),
    .endian_strap(endian_strap),
    .bus_select_strap_high(bus_select_strap_high),
    .bus_select_strap_mid(bus_select_strap_mid),
    .bus_select_strap_low(bus_select_strap_low),
    .bus_status_n(bus.bus_status_n),
    .captured(captured),
    .endian_big(endian_big),
    .mode(active_mode)
  );

  // Protocol families
  wire m_strobe = (active_mode == mode_strobe_one) || (active_mode == mode_strobe_two);
  wire m_gen1 = (active_mode == mode_generic_one);
  wire m_gen2 = (active_mode == mode_generic_two) || (active_mode == mode_vendor_one) ||
    (active_mode == mode_vendor_two);

  // Strobe modes: address strobe qualifies, A0 and the high strobe pick lanes
  wire strobe_act = !bus.cs_n && !bus.bus_status_n && (!bus.addr[0] || !bus.we1_n);
  // [R15] Separate enables qualify byte lanes
  wire gen1_wr = !bus.we0_n || !bus.we1_n;
  wire gen1_rd = !bus.rd_n || !bus.rd_wr_n;
  wire gen1_act = !bus.cs_n && (gen1_wr || gen1_rd);
  wire gen1_lo = !bus.we0_n || !bus.rd_n;
  wire gen1_hi = !bus.we1_n || !bus.rd_wr_n;
  // Generic two and vendor modes: shared strobes, A0 and high enable pick lanes
  wire gen2_act = !bus.cs_n && (!bus.we0_n || !bus.rd_n);

  wire cyc_act = captured && ((m_strobe && strobe_act) || (m_gen1 && gen1_act) ||
    (m_gen2 && gen2_act));
  wire cyc_wr = m_gen1 ? gen1_wr : (m_strobe ? !bus.rd_wr_n : !bus.we0_n);
  wire cyc_lo = m_gen1 ? gen1_lo : !bus.addr[0];
  wire cyc_hi = m_gen1 ? gen1_hi : !bus.we1_n;

  // [R02] Big endian swaps data bytes and lanes
  wire lane_lo = endian_big ? cyc_hi : cyc_lo;
  wire lane_hi = endian_big ? cyc_lo : cyc_hi;
  wire [15:0] data_in = endian_big ? swap16(bus.data) : bus.data;

  // [R07] Window decode over the 17-bit address
  // [R09] Display buffer from window base
  wire in_buf = cap_addr < `BUF_LIMIT;
  // [R08] Registers in top 32 bytes
  wire in_reg = cap_addr >= `REG_BASE;
  wire [15:0] buf_index = cap_addr[16:1];
  wire [3:0] reg_index = cap_addr[4:1];
  wire [15:0] config_word = {12'h000, endian_big, active_mode};
  wire [15:0] reg_word = (reg_index == `REG_CONFIG) ? config_word : regs[reg_index];
  wire [15:0] read_word = in_buf ? mem[buf_index] : (in_reg ? reg_word : 16'h0000);
  wire [15:0] lane_mask = {{8{cap_hi}}, {8{cap_lo}}};
  wire [15:0] read_out = endian_big ? swap16(read_word & lane_mask) : (read_word & lane_mask);
  wire do_write = (state == dev_access) && cap_wr;
  wire buf_write = do_write && in_buf;
  wire reg_write = do_write && in_reg && (reg_index != `REG_CONFIG);
  wire [4:0] busy_len = refresh_len(regs[`REG_MODE][1:0]);

  // [R04] Refresh slots; length set by panel mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_count <= 4'h0;
      refresh_busy <= 1'b0;
    end else begin
      ref_count <= ref_count + 4'h1;
      refresh_busy <= {1'b0, ref_count} < busy_len;
    end
  end

  // Display buffer write with byte lanes
  always_ff @(posedge pclk) begin
    if (buf_write) begin
      if (cap_lo) begin
        mem[buf_index][7:0] <= cap_wdata[7:0];
      end
      if (cap_hi) begin
        mem[buf_index][15:8] <= cap_wdata[15:8];
      end
    end
  end

  // Register file; the mode register steers refresh length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `REG_WORDS; i++) begin
        regs[i] <= `REG_RESET;
      end
    end else if (reg_write) begin
      if (cap_lo) begin
        regs[reg_index][7:0] <= cap_wdata[7:0];
      end
      if (cap_hi) begin
        regs[reg_index][15:8] <= cap_wdata[15:8];
      end
    end
  end

  // Cycle capture at the start of a host cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_addr <= 17'h00000;
      cap_wr <= 1'b0;
      cap_lo <= 1'b0;
      cap_hi <= 1'b0;
      cap_wdata <= 16'h0000;
    end else if (state == dev_idle && cyc_act) begin
      cap_addr <= bus.addr;
      cap_wr <= cyc_wr;
      cap_lo <= lane_lo;
      cap_hi <= lane_hi;
      cap_wdata <= data_in;
    end
  end

  // Wait-state sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dev_idle;
      sync_count <= 2'h0;
      bus.wait_n <= 1'b0;
      bus.dev_data <= 16'h0000;
      bus.dev_data_oe <= 1'b0;
    end else begin
      case (state)
        dev_idle: begin
          sync_count <= 2'h0;
          if (cyc_act) begin
            state <= dev_sync;
          end
        end
        // [R04] Synchronise to the LCD side
        dev_sync: begin
          sync_count <= sync_count + 2'h1;
          if (!cyc_act) begin
            state <= dev_idle;
          end else if (sync_count == `SYNC_CYCLES - 2'h1) begin
            state <= dev_arb;
          end
        end
        // [R14] Hold wait while refresh owns memory
        dev_arb: begin
          if (!cyc_act) begin
            state <= dev_idle;
          end else if (!refresh_busy) begin
            state <= dev_access;
          end
        end
        dev_access: begin
          bus.dev_data <= read_out;
          bus.dev_data_oe <= !cap_wr;
          // [R14] Release wait once data is valid or accepted
          bus.wait_n <= 1'b1;
          state <= dev_done;
        end
        dev_done: begin
          if (!cyc_act) begin
            bus.wait_n <= 1'b0;
            bus.dev_data_oe <= 1'b0;
            state <= dev_idle;
          end
        end
        default: begin
          state <= dev_idle;
        end
      endcase
    end
  end
endmodule

/* File: rtl/host_port_params.svh */
// Constants shared by the LCD host port, its strap latch and the CPU-side master.
// Assumes inclusion by bare name from files under rtl/.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Device window: 128K bytes, byte address of 17 bits
`define BUF_LIMIT 17'h14000
`define REG_BASE 17'h1ffe0
`define BUF_WORDS 40960
`define REG_WORDS 16

// Strap codes of the three bus select straps
`define STRAP_VENDOR_ONE 3'h0
`define STRAP_VENDOR_TWO 3'h1
`define STRAP_STROBE_ONE 3'h3
`define STRAP_STROBE_TWO 3'h5
`define STRAP_GENERIC 3'h7

// Device registers (word index inside the top 32 bytes)
`define REG_MODE 4'h0
`define REG_CONFIG 4'h1
`define REG_RESET 16'h0000

// Wait-state generation
`define SYNC_CYCLES 2'h2
`define REFRESH_ONE 5'h01

// Host chip-select and mode register settings
`define CS_WAIT_EXTERNAL 3'h7
`define CSCFG_RESET 32'h00070000
`define MODE_RESET 32'h00000001

// Host APB register offsets
`define APB_CTRL 8'h00
`define APB_ADDR 8'h04
`define APB_WDATA 8'h08
`define APB_RDATA 8'h0c
`define APB_STATUS 8'h10
`define APB_CSCFG 8'h14
`define APB_MODE 8'h18

`endif

/* File: rtl/host_port_pkg.sv */
// Types shared by the LCD host port and the CPU-side master.
// Assumes nothing of its surroundings.
package host_port_pkg;

  typedef enum logic [2:0] {
    mode_vendor_one = 3'h0,
    mode_vendor_two = 3'h1,
    mode_strobe_one = 3'h2,
    mode_strobe_two = 3'h3,
    mode_generic_one = 3'h4,
    mode_generic_two = 3'h5,
    mode_reserved = 3'h6
  } host_mode_e;

  typedef enum logic [2:0] {
    dev_idle = 3'h0,
    dev_sync = 3'h1,
    dev_arb = 3'h2,
    dev_access = 3'h3,
    dev_done = 3'h4
  } dev_state_e;

  typedef enum logic [1:0] {
    host_idle = 2'h0,
    host_wait = 2'h1,
    host_recover = 2'h2
  } host_state_e;

  typedef enum logic [1:0] {
    style_strobe = 2'h0,
    style_generic_one = 2'h1,
    style_generic_two = 2'h2
  } bus_style_e;

endpackage

/* File: rtl/host_port_if.sv */
// Host bus between the CPU-side master with its glue and the LCD host port.
// Assumes both ends run on the same bus clock; data resolves by output enables.
`timescale 1ns/10ps
interface host_port_if;
  logic [16:0] addr;
  logic [15:0] host_data;
  logic host_data_oe;
  logic [15:0] dev_data;
  logic dev_data_oe;
  logic [15:0] data;
  logic cs_n;
  logic bus_status_n;
  logic rd_wr_n;
  logic rd_n;
  logic we0_n;
  logic we1_n;
  logic wait_n;

  // Undriven bus floats high through the pull-ups
  assign data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 16'hffff);

  modport device (
    input addr, data, cs_n, bus_status_n, rd_wr_n, rd_n, we0_n, we1_n,
    output dev_data, dev_data_oe, wait_n
  );
  modport host (
    output addr, host_data, host_data_oe, cs_n, bus_status_n, rd_wr_n, rd_n, we0_n, we1_n,
    input data, wait_n
  );
endinterface

/* File: rtl/strap_latch.sv */
// Captures the configuration straps once after reset and decodes the bus mode.
// Assumes straps are stable around the release of presetn.
`timescale 1ns/10ps
`include "host_port_params.svh"
module strap_latch (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Straps and bus status
  input wire logic endian_strap,
  input wire logic bus_select_strap_high,
  input wire logic bus_select_strap_mid,
  input wire logic bus_select_strap_low,
  input wire logic bus_status_n,
  // Latched configuration
  output logic captured,
  output logic endian_big,
  output host_port_pkg::host_mode_e mode
);
  import host_port_pkg::*;

  function automatic host_mode_e decode_mode(input logic [2:0] code, input logic bs_n);
    case (code)
      `STRAP_VENDOR_ONE: decode_mode = mode_vendor_one;
      `STRAP_VENDOR_TWO: decode_mode = mode_vendor_two;
      `STRAP_STROBE_ONE: decode_mode = mode_strobe_one;
      `STRAP_STROBE_TWO: decode_mode = mode_strobe_two;
      `STRAP_GENERIC: decode_mode = bs_n ? mode_generic_two : mode_generic_one;
      default: decode_mode = mode_reserved;
    endcase
  endfunction

  wire [2:0] select_code = {bus_select_strap_high, bus_select_strap_mid, bus_select_strap_low};
  wire host_mode_e strap_mode = decode_mode(select_code, bus_status_n);

  // [R01] Sample on reset release
  // [R16] Hold until next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured <= 1'b0;
      endian_big <= 1'b0;
      mode <= mode_reserved;
    end else if (!captured) begin
      captured <= 1'b1;
      // [R02] Byte order strap
      endian_big <= endian_strap;
      // [R03] Bus protocol select
      mode <= strap_mode;
    end
  end
endmodule

/* File: rtl/cpu_bus_master.sv */
// CPU-side end: APB-programmed chip select and bus cycles toward the LCD host port.
// Assumes an APB master on the user side and the device end on the same clock.
`timescale 1ns/10ps
`include "host_port_params.svh"
module cpu_bus_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host bus
  host_port_if.host bus
);
  import host_port_pkg::*;

  host_state_e state;
  logic [31:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [31:0] cscfg;
  logic [31:0] mode_reg;
  logic cyc_wr;
  logic [1:0] cyc_be;
  logic [2:0] wait_count;
  logic done;
  logic no_select;
  logic blocked;
  logic early;

  wire access = psel && penable && pready;
  wire wr_ctrl = access && pwrite && (paddr == `APB_CTRL);
  wire start = wr_ctrl && pwdata[0] && (state == host_idle);
  wire start_wr = pwdata[1];
  wire [1:0] start_be = pwdata[3:2];
  wire [2:0] wait_field = cscfg[18:16];
  wire read_only_attribute = cscfg[20];
  // [R13] One dedicated select; not boot or card slot
  // [R07] Select decodes one 128K block
  wire cs_hit = addr_reg[31:17] == cscfg[14:0];
  // [R11] Read-only select blocks writes
  wire write_blocked = start_wr && read_only_attribute;
  // [R12] Strobe pins in other use force generic one
  wire alt_pins = mode_reg[4];
  wire bus_style_e style = alt_pins ? style_generic_one : bus_style_e'(mode_reg[1:0]);
  // [R06] Inverter enabled by the select
  wire ack = !bus.cs_n && bus.wait_n;
  wire transfer_acknowledge_n = !ack;
  // [R10] Wait field 111b lets the device end the cycle
  wire external_end = wait_field == `CS_WAIT_EXTERNAL;
  // [R05] Acknowledge ends the cycle in every style when the wait field is 111b
  wire cyc_end = external_end ? !transfer_acknowledge_n : (wait_count == wait_field);
  wire mapped = (paddr <= `APB_MODE) && (paddr[1:0] == 2'h0);
  wire [31:0] status_word = {27'h0, early, blocked, no_select, done, state != host_idle};
  wire [31:0] read_mux = (paddr == `APB_ADDR) ? addr_reg :
    (paddr == `APB_WDATA) ? {16'h0, wdata_reg} :
    (paddr == `APB_RDATA) ? {16'h0, rdata_reg} :
    (paddr == `APB_STATUS) ? status_word :
    (paddr == `APB_CSCFG) ? cscfg :
    (paddr == `APB_MODE) ? mode_reg : 32'h0;

  // APB slave: one wait state, writes take effect on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      addr_reg <= 32'h0;
      wdata_reg <= 16'h0;
      cscfg <= `CSCFG_RESET;
      mode_reg <= `MODE_RESET;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= read_mux;
      if (access && pwrite && paddr == `APB_ADDR) begin
        addr_reg <= pwdata;
      end
      if (access && pwrite && paddr == `APB_WDATA) begin
        wdata_reg <= pwdata[15:0];
      end
      if (access && pwrite && paddr == `APB_CSCFG) begin
        cscfg <= pwdata;
      end
      if (access && pwrite && paddr == `APB_MODE) begin
        mode_reg <= pwdata;
      end
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= host_idle;
      cyc_wr <= 1'b0;
      cyc_be <= 2'h0;
      wait_count <= 3'h0;
      rdata_reg <= 16'h0;
      {done, no_select, blocked, early} <= 4'h0;
      bus.addr <= 17'h0;
      bus.host_data <= 16'h0;
      bus.host_data_oe <= 1'b0;
      {bus.cs_n, bus.rd_wr_n, bus.rd_n, bus.we0_n, bus.we1_n} <= 5'h1f;
      // Reset style is generic one, whose status pin is tied low; the straps see that
      bus.bus_status_n <= 1'b0;
    end else begin
      case (state)
        host_idle: begin
          // Idle status level follows the style: low in generic one, high otherwise
          bus.bus_status_n <= (style != style_generic_one);
          if (start) begin
            {done, no_select, blocked, early} <= 4'h0;
            cyc_wr <= start_wr;
            cyc_be <= start_be;
            wait_count <= 3'h0;
            if (!cs_hit || write_blocked || start_be == 2'h0) begin
              done <= 1'b1;
              no_select <= !cs_hit;
              blocked <= cs_hit && write_blocked;
            end else begin
              state <= host_wait;
              bus.cs_n <= 1'b0;
              bus.addr <= {addr_reg[16:1], 1'b0};
              bus.host_data <= wdata_reg;
              bus.host_data_oe <= start_wr;
              bus.bus_status_n <= (style == style_generic_two);
              if (style == style_generic_one) begin
                bus.we0_n <= !(start_wr && start_be[0]);
                bus.we1_n <= !(start_wr && start_be[1]);
                bus.rd_n <= !(!start_wr && start_be[0]);
                bus.rd_wr_n <= !(!start_wr && start_be[1]);
              end else begin
                bus.addr[0] <= !start_be[0];
                bus.we1_n <= !start_be[1];
                bus.rd_wr_n <= (style == style_strobe) ? !start_wr : 1'b1;
                bus.we0_n <= !((style == style_generic_two) && start_wr);
                bus.rd_n <= !((style == style_generic_two) && !start_wr);
              end
            end
          end
        end
        host_wait: begin
          wait_count <= wait_count + 3'h1;
          if (cyc_end) begin
            if (!cyc_wr) begin
              rdata_reg <= bus.data;
            end
            early <= !external_end;
            done <= 1'b1;
            bus.host_data_oe <= 1'b0;
            {bus.cs_n, bus.rd_wr_n, bus.rd_n, bus.we0_n, bus.we1_n} <= 5'h1f;
            bus.bus_status_n <= (style != style_generic_one);
            state <= host_recover;
          end
        end
        host_recover: begin
          if (!bus.wait_n) begin
            state <= host_idle;
          end
        end
        default: begin
          state <= host_idle;
        end
      endcase
    end
  end
endmodule

/* File: test/host_port_chk.sv */
// Assertions on the host bus between the CPU-side master and the LCD host port.
// Assumes one clock domain; instantiated by the bench top beside the interface.
`timescale 1ns/10ps
module host_port_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wait_n,
  input wire logic dev_data_oe,
  // Latched configuration
  input wire logic endian_big,
  input wire host_port_pkg::host_mode_e active_mode
);
  import host_port_pkg::*;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cycle_taken;
    $fell(cs_n);
  endsequence
  sequence wait_held;
    !wait_n [*4];
  endsequence

  min_wait_a: assert property (cycle_taken |-> wait_held)
    else $error("wait ended before sync and access");
  idle_low_a: assert property (cs_n && $past(cs_n) |-> !wait_n)
    else $error("wait high outside a cycle");
  hold_high_a: assert property (wait_n && !cs_n |=> wait_n || cs_n)
    else $error("wait dropped while cycle still active");
  drop_low_a: assert property ($rose(cs_n) |=> !wait_n)
    else $error("wait not lowered after cycle end");
  read_data_a: assert property ($rose(wait_n) && !rd_n |-> dev_data_oe)
    else $error("read answered without data driven");
  own_select_a: assert property (dev_data_oe |-> !cs_n || !$past(cs_n))
    else $error("device drives data while not selected");
  reserved_a: assert property (active_mode == mode_reserved |-> !wait_n)
    else $error("reserved mode answered a cycle");
  mode_hold_a: assert property ($past(presetn) && $past(presetn, 2) |->
    $stable(active_mode) && $stable(endian_big))
    else $error("configuration changed after capture");
endmodule

/* File: test/host_bus_strap_and_wait_port_tb.sv */
// Bench joining the CPU-side master and the LCD host port through the host bus.
// Assumes APB register map and bus timing of both ends as handed over.
`timescale 1ns/10ps
`include "host_port_params.svh"
module host_bus_strap_and_wait_port_tb;
  import host_port_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic [3:0] straps = 4'h7;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, st, rd, q;
  logic pready, pslverr, endian_big, refresh_busy, err;
  host_mode_e active_mode;
  int errors = 0;
  int n_compared = 0;

  always #12.5 pclk = ~pclk;

  host_port_if bus_if();
  lcd_host_port lcd_host_port_inst (.pclk(pclk), .presetn(presetn),
    .endian_strap(straps[3]), .bus_select_strap_high(straps[2]),
    .bus_select_strap_mid(straps[1]), .bus_select_strap_low(straps[0]), .bus(bus_if),
    .endian_big(endian_big), .active_mode(active_mode), .refresh_busy(refresh_busy));
  cpu_bus_master cpu_bus_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if));
  host_port_chk host_port_chk_inst (.pclk(pclk), .presetn(presetn), .cs_n(bus_if.cs_n),
    .rd_n(bus_if.rd_n), .wait_n(bus_if.wait_n), .dev_data_oe(bus_if.dev_data_oe),
    .endian_big(endian_big), .active_mode(active_mode));

  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task test_done();
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task do_reset(input logic [3:0] s);
    @(posedge pclk);
    presetn <= 0;
    straps <= s;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50)
      errors++;
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // One host cycle toward the device, then status and read data
  task dev(input logic w, input logic [31:0] a, input logic [15:0] d, input logic [1:0] be);
    int n;
    apb(1'b1, `APB_ADDR, a);
    apb(1'b1, `APB_WDATA, {16'h0, d});
    apb(1'b1, `APB_CTRL, {28'h0, be, w, 1'b1});
    n = 0;
    do begin
      apb(1'b0, `APB_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    check({31'h0, q[0]}, 32'h0, "host cycle never ended");
    st = q;
    apb(1'b0, `APB_RDATA, 32'h0);
    rd = q;
  endtask

  task t_straps();
    logic [2:0] exp [8];
    // Host resets into generic one, so its status pin reads low at capture
    exp = '{3'h0, 3'h1, 3'h6, 3'h2, 3'h6, 3'h3, 3'h6, 3'h4};
    for (int i = 0; i < 8; i++) begin
      do_reset({i[0], i[2:0]});
      check({29'h0, active_mode}, {29'h0, exp[i]}, "strap mode");
      check({31'h0, endian_big}, {31'h0, i[0]}, "strap endian");
    end
    straps <= 4'h0;
    repeat (5) @(posedge pclk);
    check({29'h0, active_mode}, 32'h4, "mode followed straps");
    check({31'h0, endian_big}, 32'h1, "endian followed straps");
  endtask

  task t_reserved();
    do_reset(4'h2);
    apb(1'b1, `APB_ADDR, 32'h0);
    apb(1'b1, `APB_CTRL, 32'hd);
    repeat (40) begin
      @(posedge pclk);
      check({31'h0, bus_if.wait_n}, 32'h0, "reserved mode answered");
    end
  endtask

  task t_window();
    logic [31:0] a [4];
    logic [31:0] e [4];
    a = '{32'h0, 32'h13ffe, 32'h14000, 32'h1ffe4};
    e = '{32'h1234, 32'h5a5a, 32'h0, 32'hbeef};
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, a[i], e[i][15:0] | 16'h0001 & {16{i == 2}}, 2'b11);
      check({31'h0, st[1]}, 32'h1, "write not done");
    end
    for (int i = 0; i < 4; i++) begin
      dev(1'b0, a[i], 16'h0, 2'b11);
      check({16'h0, rd[15:0]}, e[i], "window read");
    end
    dev(1'b1, 32'h0, 16'habcd, 2'b01);
    dev(1'b0, 32'h0, 16'h0, 2'b11);
    check({16'h0, rd[15:0]}, 32'h12cd, "low lane write");
  endtask

  task t_select();
    dev(1'b1, 32'h4, 16'h1111, 2'b11);
    dev(1'b0, 32'h20000, 16'h0, 2'b11);
    check({31'h0, st[2]}, 32'h1, "outside window selected");
    apb(1'b1, `APB_CSCFG, 32'h00170000);
    dev(1'b1, 32'h4, 16'h7777, 2'b11);
    check({31'h0, st[3]}, 32'h1, "read-only write not blocked");
    apb(1'b1, `APB_CSCFG, 32'h0);
    dev(1'b0, 32'h4, 16'h0, 2'b11);
    check({31'h0, st[4]}, 32'h1, "internal count not used");
    apb(1'b1, `APB_CSCFG, `CSCFG_RESET);
    dev(1'b0, 32'h4, 16'h0, 2'b11);
    check({31'h0, st[4]}, 32'h0, "external end not used");
    check({16'h0, rd[15:0]}, 32'h1111, "blocked write landed");
  endtask

  // Every answering strap mode except generic two, with its host style; the buffer keeps its word over reset
  task t_modes();
    logic [3:0] s [5];
    logic [31:0] m [5];
    logic [15:0] d [5];
    s = '{4'h0, 4'h1, 4'h3, 4'h5, 4'hf};
    m = '{32'h2, 32'h2, 32'h0, 32'h0, 32'h1};
    d = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h1234};
    for (int i = 0; i < 5; i++) begin
      do_reset(s[i]);
      apb(1'b1, `APB_MODE, m[i]);
      dev(1'b1, 32'h6, d[i], 2'b11);
      dev(1'b0, 32'h6, 16'h0, 2'b11);
      check({16'h0, rd[15:0]}, {16'h0, d[i]}, "mode round trip");
    end
    do_reset(4'h7);
    dev(1'b0, 32'h6, 16'h0, 2'b11);
    check({16'h0, rd[15:0]}, 32'h3412, "big endian bytes not swapped");
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    t_straps();
    t_reserved();
    do_reset(4'h7);
    apb(1'b0, `APB_CSCFG, 32'h0);
    check(q, `CSCFG_RESET, "select config reset");
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped offset accepted");
    // Strobe pins in other use: the host must fall back to generic one
    apb(1'b1, `APB_MODE, 32'h10);
    t_window();
    t_select();
    t_modes();
    test_done();
  end

  initial begin
    #500000;
    errors++;
    test_done();
  end
endmodule
